// *** design/sgsc_defines.svh ***
// Functional notes
// - Six-bit word, most significant bit first
// - Inverted binary code, half-dB steps
// - Codes at or below 000100 give 29.5 dB
// - Power-up word is all zeros
// - Select high: serial clock ignored
// - Select low: bits shift into register
// - Select rising edge latches shifted word
// - Standby low turns amplifier off
// - Port works in standby; word held
// - Standby high gives full operation
`ifndef SGSC_DEFINES_SVH
`define SGSC_DEFINES_SVH

`define SGSC_WORD_W 6
`define SGSC_RESET_WORD 6'h00
`define SGSC_MIN_CODE 6'h04
`define SGSC_ATTEN_MAX_HALF_DB 6'h3b
`define SGSC_BIT_16DB 5
`define SGSC_BIT_8DB 4
`define SGSC_BIT_4DB 3
`define SGSC_BIT_2DB 2
`define SGSC_BIT_1DB 1
`define SGSC_BIT_HALF_DB 0
`define SGSC_SEL_TO_CLK_GAP_NS 5

`endif

// *** design/sgsc_pkg.sv ***
`default_nettype none
`include "sgsc_defines.svh"

package sgsc_pkg;

    typedef logic [`SGSC_WORD_W-1:0] sgsc_word_type;

    typedef struct packed {
        logic rst_meta;
        logic rst_hold;
        sgsc_word_type shift;
    } sgsc_link_state_type;

    typedef struct packed {
        logic sel_meta;
        logic sel_sync;
        logic sel_prev;
        logic pwr_meta;
        logic pwr_sync;
        logic amp_on;
        logic loaded;
        sgsc_word_type word;
        sgsc_word_type atten;
    } sgsc_core_state_type;

endpackage

`default_nettype wire

// *** design/sgsc_shift.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sgsc_defines.svh"

module sgsc_shift (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic rst,
    // Serial pins
    input wire logic serial_select_n,
    input wire logic serial_data,
    // Shifted word
    output sgsc_pkg::sgsc_word_type shift_word
);
    import sgsc_pkg::*;

    sgsc_link_state_type state_reg;
    sgsc_link_state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        state_next.rst_meta = rst;
        state_next.rst_hold = state_reg.rst_meta;
        if (state_reg.rst_hold) begin
            state_next.shift = `SGSC_RESET_WORD;
        end else if (!serial_select_n) begin
            // Oldest bit falls off the top
            state_next.shift = {state_reg.shift[`SGSC_WORD_W-2:0], serial_data};
        end
        // Select high outside reset leaves the register untouched
    end

    always_ff @(posedge link_clk) begin
        state_reg <= state_next;
    end

    assign shift_word = state_reg.shift;

    ////////////////////////////////////////////////////////////////////////
    a_shift_ignored: assert property (
        @(posedge link_clk) disable iff (state_reg.rst_hold)
        serial_select_n |=> $stable(state_reg.shift))
        else $error("shift register moved while select high");

    a_shift_msb_first: assert property (
        @(posedge link_clk) disable iff (state_reg.rst_hold)
        !serial_select_n |=> state_reg.shift[0] == $past(serial_data)
            && state_reg.shift[5:1] == $past(state_reg.shift[4:0]))
        else $error("bit not shifted in at the bottom");

    a_six_bits_kept: assert property (
        @(posedge link_clk) disable iff (state_reg.rst_hold)
        (!serial_select_n) [*6] |=> state_reg.shift[5] == $past(serial_data, 6))
        else $error("top bit is not the sixth-last bit shifted");

    c_six_clocks: cover property (
        @(posedge link_clk) disable iff (state_reg.rst_hold)
        (!serial_select_n) [*6] ##1 serial_select_n);

endmodule

`default_nettype wire

// *** design/sgsc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sgsc_defines.svh"

module sgsc_top (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial port pins
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_data,
    // Standby pin
    input wire logic low_power_n,
    // Active setting
    output sgsc_pkg::sgsc_word_type gain_step_word,
    output logic atten_bit_16db,
    output logic atten_bit_8db,
    output logic atten_bit_4db,
    output logic atten_bit_2db,
    output logic atten_bit_1db,
    output logic atten_bit_half_db,
    output sgsc_pkg::sgsc_word_type atten_half_db_steps,
    // Status
    output logic amp_enable,
    output logic word_loaded
);
    import sgsc_pkg::*;

    sgsc_core_state_type state_reg;
    sgsc_core_state_type state_next;
    sgsc_word_type shift_word;
    logic sel_rise;

    ////////////////////////////////////////////////////////////////////////
    // Attenuation in half-dB units
    function automatic sgsc_word_type atten_of(input sgsc_word_type code);
        if (code < `SGSC_MIN_CODE) begin
            atten_of = `SGSC_ATTEN_MAX_HALF_DB;
        end else begin
            atten_of = ~code;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain
    sgsc_shift u_shift (
        .link_clk(serial_clk),
        .rst(rst),
        .serial_select_n(serial_select_n),
        .serial_data(serial_data),
        .shift_word(shift_word)
    );

    ////////////////////////////////////////////////////////////////////////
    assign sel_rise = state_reg.sel_sync && !state_reg.sel_prev;

    always_comb begin
        state_next = state_reg;
        state_next.sel_meta = serial_select_n;
        state_next.sel_sync = state_reg.sel_meta;
        state_next.sel_prev = state_reg.sel_sync;
        state_next.pwr_meta = low_power_n;
        state_next.pwr_sync = state_reg.pwr_meta;
        state_next.amp_on = state_reg.pwr_sync;
        state_next.loaded = 1'b0;
        if (rst) begin
            state_next.sel_meta = 1'b1;
            state_next.sel_sync = 1'b1;
            state_next.sel_prev = 1'b1;
            state_next.pwr_meta = 1'b0;
            state_next.pwr_sync = 1'b0;
            state_next.amp_on = 1'b0;
            state_next.word = `SGSC_RESET_WORD;
            state_next.atten = atten_of(`SGSC_RESET_WORD);
        end else if (sel_rise) begin
            // Word is quiet here: no shifting until select falls again
            state_next.word = shift_word;
            state_next.atten = atten_of(shift_word);
            state_next.loaded = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////
    assign gain_step_word = state_reg.word;
    assign atten_bit_16db = state_reg.word[`SGSC_BIT_16DB];
    assign atten_bit_8db = state_reg.word[`SGSC_BIT_8DB];
    assign atten_bit_4db = state_reg.word[`SGSC_BIT_4DB];
    assign atten_bit_2db = state_reg.word[`SGSC_BIT_2DB];
    assign atten_bit_1db = state_reg.word[`SGSC_BIT_1DB];
    assign atten_bit_half_db = state_reg.word[`SGSC_BIT_HALF_DB];
    assign atten_half_db_steps = state_reg.atten;
    assign amp_enable = state_reg.amp_on;
    assign word_loaded = state_reg.loaded;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_reset_word: assert property (
        @(posedge core_clk) disable iff (1'b0)
        rst |=> gain_step_word == 6'h00 && atten_half_db_steps == 6'h3b)
        else $error("power-up word is not all zeros");

    a_load_on_rise: assert property (
        $rose(state_reg.sel_sync) |=> gain_step_word == $past(shift_word) && word_loaded)
        else $error("word not latched on select rise");

    a_hold_between: assert property (
        !sel_rise |=> $stable(gain_step_word) && !word_loaded)
        else $error("active word changed without select rise");

    a_pin_to_load: assert property (
        $rose(serial_select_n) |-> ##[3:4] word_loaded)
        else $error("select rise not answered within four cycles");

    a_standby_load: assert property (
        (sel_rise && !amp_enable) |=> gain_step_word == $past(shift_word))
        else $error("word not accepted during standby");

    a_amp_follows: assert property (
        $changed(low_power_n) ##1 $stable(low_power_n) [*3]
        |-> amp_enable == low_power_n)
        else $error("amplifier enable does not follow standby pin");

    a_full_operation: assert property (
        low_power_n [*4] |=> amp_enable)
        else $error("amplifier off with standby pin high");

    a_atten_map: assert property (
        gain_step_word >= 6'h04 |-> atten_half_db_steps == ~gain_step_word)
        else $error("attenuation does not match inverted code");

    a_atten_clamp: assert property (
        gain_step_word < 6'h04 |-> atten_half_db_steps == 6'h3b)
        else $error("low code does not give full attenuation");

    c_load: cover property (word_loaded);
    c_standby_load: cover property (word_loaded && !amp_enable);
    c_clamp_code: cover property (word_loaded && gain_step_word < 6'h04);
    c_zero_atten: cover property (word_loaded && gain_step_word == 6'h3f);

endmodule

`default_nettype wire

// *** verification/serial_gain_step_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_gain_step_control_test;
    import sgsc_pkg::*;
    logic core_clk, rst, low_power_n, amp_enable, word_loaded;
    wire logic serial_clk, serial_select_n, serial_data;
    sgsc_word_type gain_step_word, atten_half_db_steps, e;
    logic [5:0] bits;
    logic [15:0] lfsr;
    int fail_count, cmp_count, cyc;
    sgsc_word_type exp_q[$];
    sgsc_word_type codes[12] = '{6'h3f, 6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h2f,
                                 6'h1f, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

    sgsc_ctrl_model u_ctrl (.serial_clk(serial_clk), .serial_select_n(serial_select_n),
        .serial_data(serial_data));

    sgsc_top u_dut (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
        .serial_select_n(serial_select_n), .serial_data(serial_data),
        .low_power_n(low_power_n), .gain_step_word(gain_step_word),
        .atten_bit_16db(bits[5]), .atten_bit_8db(bits[4]), .atten_bit_4db(bits[3]),
        .atten_bit_2db(bits[2]), .atten_bit_1db(bits[1]), .atten_bit_half_db(bits[0]),
        .atten_half_db_steps(atten_half_db_steps), .amp_enable(amp_enable),
        .word_loaded(word_loaded));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic frame(input logic [7:0] w, input logic [5:0] x, input int n);
        @(posedge core_clk);
        #1 exp_q.push_back(x);
        u_ctrl.send(w, n);
        repeat (8) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // Each load pops the oldest expected word
    always @(posedge core_clk) begin
        if (!rst && word_loaded === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected load", 8'h01, 8'h00);
            else begin
                e = exp_q.pop_front();
                check("word", gain_step_word, e);
                check("bits", bits, e);
                check("steps", atten_half_db_steps, (e < 6'h04) ? 6'h3b : 6'h3f - e);
            end
        end
    end

    initial begin
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
        lfsr = 16'h2b68;
        rst = 1'b1;
        low_power_n = 1'b1;
        // Serial clock runs in reset so the shift register clears
        #1 u_ctrl.stray(4);
        repeat (7) @(posedge core_clk);
        #1 rst = 1'b0;
        @(posedge core_clk);
        #1 check("reset word", gain_step_word, 6'h00);
        check("reset steps", atten_half_db_steps, 6'h3b);
        // Serial-side reset drains before the first frame
        u_ctrl.stray(3);
        repeat (4) @(posedge core_clk);
        #1 check("amp on", amp_enable, 1'b1);
        foreach (codes[i]) frame({2'h0, codes[i]}, codes[i], 6);
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            frame(lfsr[7:0], lfsr[5:0], 6);
        end
        frame(8'ha5, 6'h25, 8);
        u_ctrl.stray(8);
        frame(8'h03, 6'h2b, 3);
        #1 low_power_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 check("amp off", amp_enable, 1'b0);
        frame(8'h15, 6'h15, 6);
        #1 low_power_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 check("amp back", amp_enable, 1'b1);
        check("held word", gain_step_word, 6'h15);
        check("pending loads", 8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule

`default_nettype wire

// *** verification/sgsc_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sgsc_ctrl_model (
    // Serial pins
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_data
);
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_data = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Frame of n bits, msb first; clock runs only inside the frame
    task automatic send(input logic [7:0] w, input int n);
        serial_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
        #6 serial_select_n = 1'b1;
        serial_data = ~serial_data;
    endtask

    // Clock edges with select high, data toggling
    task automatic stray(input int n);
        repeat (n) begin
            serial_data = ~serial_data;
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire
